//--- src/adc_feature_map.svh
// register offsets, field positions, reset values and timing counts of the feature control block
`ifndef ADC_FEATURE_MAP_SVH
`define ADC_FEATURE_MAP_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define ADDR_MODE 8'h00
`define ADDR_FILTER_A 8'h04
`define ADDR_FILTER_B 8'h08
`define ADDR_CONTROL 8'h0C
`define ADDR_STATUS 8'h10

// ****************************************
// field positions
// ****************************************
`define MODE_BIT_ONE 0
`define MODE_BIT_TWO 1
`define CTRL_BYPASS_BIT 0
`define CTRL_ENA_A_BIT 1
`define CTRL_ENA_B_BIT 2
`define ST_NS_A_BIT 0
`define ST_NS_B_BIT 1
`define ST_FEAT_BIT 2
`define ST_PDOWN_BIT 3
`define ST_STBY_BIT 4
`define ST_MUX_BIT 5
`define ST_RSVD_BIT 6

// ****************************************
// widths, limits and reset values
// ****************************************
`define FILTER_W 6
`define FILTER_COUNT 6'h37
`define FILTER_LAST 6'h36
`define FILTER_RESET 6'h00
`define MODE_RESET 2'h0
`define CTRL_RESET 3'h0
`define SAMPLE_W 11
`define LATENCY_CYCLES 16
`define WIDE_RATE_MHZ 184
`define NARROW_RATE_MHZ 200
`define WIDE_CLASS_FIRST 6'h1E
`define CLASS_60_FIRST 6'h28
`define CLASS_30_FIRST 6'h15
`define CLASS_30_LAST 6'h1C

`endif

//--- src/adc_feature_pkg.sv
// types shared by the feature control block
package adc_feature_pkg;
  typedef logic [5:0] filter_index_t;
  typedef logic [10:0] sample_t;
  typedef logic [7:0] reg_addr_t;
  typedef logic [31:0] reg_data_t;
  typedef enum logic [1:0] {
    mode_default = 2'b00,
    mode_shaping_only = 2'b01,
    mode_all_features = 2'b10
  } feature_mode_t;
  typedef enum logic [1:0] {
    class_20 = 2'b00,
    class_30 = 2'b01,
    class_40 = 2'b10,
    class_60 = 2'b11
  } bw_class_t;
  typedef enum logic [2:0] {
    pin_normal = 3'b000,
    pin_power_down = 3'b001,
    pin_standby_a = 3'b010,
    pin_reserved = 3'b011,
    pin_mux = 3'b100
  } pin_state_t;
endpackage

//--- src/adc_feature_ctrl.sv
// digital feature and noise shaping control of a dual channel converter
// Notes on behaviour
// - two mode bits steer test pattern, gain, offset and noise shaping, and zero in both means default operation.
// - mode bits 0,1 enable noise shaping only and bypass test pattern, gain and offset correction.
// - first mode bit set enables noise shaping and all other digital features whatever the second bit holds.
// - one of 55 preset filters is chosen by a filter index field.
// - each channel has its own filter index field.
// - the presets fall into four bandwidth classes with several centres each.
// - bandwidth and centre are fixed fractions of the sample rate, referenced to 184 or 200 MHz.
// - after reset noise shaping is off on both channels.
// - in pin control the three control pins switch noise shaping at run time.
// - with the bypass bit set each channel follows its own register enable bit.
// - first pin low makes pins two and three the channel A and B enables.
// - first pin high selects power down, channel A standby or multiplexed output, one code reserved.
// - output words appear 16 sample clocks after their input was sampled.
`timescale 1ns/1ps
`default_nettype none
`include "adc_feature_map.svh"

module adc_feature_ctrl (
  input wire logic sys_clk,
  input wire logic srst,
  input wire adc_feature_pkg::reg_addr_t reg_addr,
  input wire adc_feature_pkg::reg_data_t reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output adc_feature_pkg::reg_data_t reg_rdata,
  input wire logic control_pin_one,
  input wire logic control_pin_two,
  input wire logic control_pin_three,
  input wire adc_feature_pkg::sample_t raw_sample_a,
  input wire adc_feature_pkg::sample_t raw_sample_b,
  output adc_feature_pkg::sample_t first_channel_output_bus,
  output adc_feature_pkg::sample_t second_channel_output_bus,
  output logic noise_shaping_on_a,
  output logic noise_shaping_on_b,
  output adc_feature_pkg::filter_index_t active_filter_a,
  output adc_feature_pkg::filter_index_t active_filter_b,
  output adc_feature_pkg::bw_class_t active_class_a,
  output adc_feature_pkg::bw_class_t active_class_b,
  output logic wide_rate_ref_a,
  output logic wide_rate_ref_b,
  output logic aux_features_on,
  output logic global_power_down,
  output logic standby_a,
  output logic mux_output
);
  import adc_feature_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  // wide presets scale from the lower reference rate; shared by class and rate decode
  function automatic logic is_wide(input filter_index_t idx);
    return idx >= `WIDE_CLASS_FIRST;
  endfunction

  // bandwidth class of a preset, used for both channels
  function automatic bw_class_t class_of(input filter_index_t idx);
    bw_class_t c;
    c = class_20;
    if (idx >= `CLASS_60_FIRST) begin
      c = class_60;
    end else if (is_wide(idx)) begin
      c = class_40;
    end else if (idx >= `CLASS_30_FIRST && idx <= `CLASS_30_LAST) begin
      c = class_30;
    end else begin
      c = class_20;
    end
    return c;
  endfunction

  // one register bus hit, shared by every writable register
  function automatic logic write_hit(input logic strobe, input reg_addr_t addr, input reg_addr_t target);
    return strobe && (addr == target);
  endfunction

  // one channel's shaping enable: registers win while bypassed, pins otherwise
  function automatic logic pick_enable(input feature_mode_t m, input logic bypass, input logic reg_en,
                                       input logic pin_en);
    logic on;
    on = 1'b0;
    if (m != mode_default) begin
      if (bypass) begin
        on = reg_en;
      end else begin
        on = pin_en;
      end
    end
    return on;
  endfunction

  function automatic feature_mode_t decode_mode(input logic [1:0] bits);
    feature_mode_t m;
    m = mode_default;
    if (bits[`MODE_BIT_ONE]) begin
      m = mode_all_features;
    end else if (bits[`MODE_BIT_TWO]) begin
      m = mode_shaping_only;
    end else begin
      m = mode_default;
    end
    return m;
  endfunction

  // ****************************************
  // configuration registers
  // ****************************************
  logic [1:0] mode_bits;
  filter_index_t noise_shaping_filter_index [2];
  logic pin_control_bypass;
  logic noise_shaping_enable_ch_a;
  logic noise_shaping_enable_ch_b;
  feature_mode_t mode;
  pin_state_t pin_state;
  logic pin_ena_a;
  logic pin_ena_b;
  logic next_on_a;
  logic next_on_b;
  logic write_mode;
  logic write_control;
  logic [1:0] write_filter;

  // ****************************************
  // write decode
  // ****************************************
  // decoded once so every register sees the same strobe qualification
  assign write_mode = write_hit(reg_write, reg_addr, `ADDR_MODE);
  assign write_control = write_hit(reg_write, reg_addr, `ADDR_CONTROL);
  assign write_filter[0] = write_hit(reg_write, reg_addr, `ADDR_FILTER_A);
  assign write_filter[1] = write_hit(reg_write, reg_addr, `ADDR_FILTER_B);

  // both bits kept as written; the decode ignores the second bit while the first is set
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_bits <= `MODE_RESET;
    end else if (write_mode) begin
      mode_bits <= reg_wdata[1:0];
    end
  end

  // out of range indices are refused so only the 55 presets can be held
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_filter
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          noise_shaping_filter_index[ch] <= `FILTER_RESET;
        end else if (write_filter[ch] && reg_wdata[`FILTER_W-1:0] <= `FILTER_LAST) begin
          noise_shaping_filter_index[ch] <= reg_wdata[5:0];
        end
      end
    end
  endgenerate

  // bypass rides in the same word as the enables, so the final write sets both at once
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_control_bypass <= 1'b0;
    end else if (write_control) begin
      pin_control_bypass <= reg_wdata[`CTRL_BYPASS_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      noise_shaping_enable_ch_a <= 1'b0;
      noise_shaping_enable_ch_b <= 1'b0;
    end else if (write_control) begin
      noise_shaping_enable_ch_a <= reg_wdata[`CTRL_ENA_A_BIT];
      noise_shaping_enable_ch_b <= reg_wdata[`CTRL_ENA_B_BIT];
    end
  end

  // ****************************************
  // control pin decode
  // ****************************************
  always_comb begin
    mode = decode_mode(mode_bits);
    pin_ena_a = 1'b0;
    pin_ena_b = 1'b0;
    pin_state = pin_normal;
    if (!control_pin_one) begin
      pin_ena_a = control_pin_two;
      pin_ena_b = control_pin_three;
      pin_state = pin_normal;
    end else begin
      case ({control_pin_two, control_pin_three})
        2'b00: pin_state = pin_power_down;
        2'b01: pin_state = pin_standby_a;
        2'b11: pin_state = pin_mux;
        default: pin_state = pin_reserved;
      endcase
    end
  end

  // ****************************************
  // noise shaping enables
  // ****************************************
  // pins are followed live without register writes; bypass hands control to registers
  always_comb begin
    next_on_a = pick_enable(mode, pin_control_bypass, noise_shaping_enable_ch_a, pin_ena_a);
    next_on_b = pick_enable(mode, pin_control_bypass, noise_shaping_enable_ch_b, pin_ena_b);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      noise_shaping_on_a <= 1'b0;
      noise_shaping_on_b <= 1'b0;
    end else begin
      noise_shaping_on_a <= next_on_a;
      noise_shaping_on_b <= next_on_b;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aux_features_on <= 1'b0;
    end else begin
      aux_features_on <= (mode == mode_all_features);
    end
  end

  // ****************************************
  // registered pin decodes
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      global_power_down <= 1'b0;
      standby_a <= 1'b0;
      mux_output <= 1'b0;
    end else begin
      global_power_down <= (pin_state == pin_power_down);
      standby_a <= (pin_state == pin_standby_a);
      mux_output <= (pin_state == pin_mux);
    end
  end

  // ****************************************
  // filter selection
  // ****************************************
  // selection as seen by the shaping filters, with its class and rate reference
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      active_filter_a <= `FILTER_RESET;
      active_filter_b <= `FILTER_RESET;
    end else begin
      active_filter_a <= noise_shaping_filter_index[0];
      active_filter_b <= noise_shaping_filter_index[1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      active_class_a <= class_20;
      active_class_b <= class_20;
    end else begin
      active_class_a <= class_of(noise_shaping_filter_index[0]);
      active_class_b <= class_of(noise_shaping_filter_index[1]);
    end
  end

  // presets from index 30 up scale from the 184 MHz reference, the rest from 200 MHz
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wide_rate_ref_a <= 1'b0;
      wide_rate_ref_b <= 1'b0;
    end else begin
      wide_rate_ref_a <= is_wide(noise_shaping_filter_index[0]);
      wide_rate_ref_b <= is_wide(noise_shaping_filter_index[1]);
    end
  end

  // ****************************************
  // output latency pipeline
  // ****************************************
  // 16 stages from the sampling edge to the output flops
  sample_t pipe_a [`LATENCY_CYCLES];
  sample_t pipe_b [`LATENCY_CYCLES];

  // reset flushes the pipe so no sample from before a reset reaches the buses
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int i = 0; i < `LATENCY_CYCLES; i++) begin
        pipe_a[i] <= '0;
        pipe_b[i] <= '0;
      end
    end else begin
      pipe_a[0] <= raw_sample_a;
      pipe_b[0] <= raw_sample_b;
      for (int i = 1; i < `LATENCY_CYCLES; i++) begin
        pipe_a[i] <= pipe_a[i-1];
        pipe_b[i] <= pipe_b[i-1];
      end
    end
  end

  // mux mode interleaves channel A onto the second bus from the same tap, so latency stays 16
  logic mux_phase;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mux_phase <= 1'b0;
    end else begin
      mux_phase <= mux_output ? ~mux_phase : 1'b0;
    end
  end

  assign first_channel_output_bus = pipe_a[`LATENCY_CYCLES-1];
  assign second_channel_output_bus = (mux_output && mux_phase) ? pipe_a[`LATENCY_CYCLES-1]
                                                                : pipe_b[`LATENCY_CYCLES-1];

  // ****************************************
  // register read port
  // ****************************************
  // the reserved flag is the live pin code; every other status bit is already registered
  reg_data_t status_word;
  reg_data_t next_rdata;
  assign status_word = {25'h0, pin_state == pin_reserved, mux_output, standby_a, global_power_down,
                        aux_features_on, noise_shaping_on_b, noise_shaping_on_a};

  always_comb begin
    next_rdata = '0;
    if (reg_read) begin
      case (reg_addr)
        `ADDR_MODE: next_rdata = {30'h0, mode_bits};
        `ADDR_FILTER_A: next_rdata = {26'h0, noise_shaping_filter_index[0]};
        `ADDR_FILTER_B: next_rdata = {26'h0, noise_shaping_filter_index[1]};
        `ADDR_CONTROL: next_rdata = {29'h0, noise_shaping_enable_ch_b, noise_shaping_enable_ch_a,
                                     pin_control_bypass};
        `ADDR_STATUS: next_rdata = status_word;
        default: next_rdata = '0;
      endcase
    end
  end

  // data stand for the one cycle after the strobe, then fall back to zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

`default_nettype wire

//--- verification/adc_feature_ctrl_sva.sv
// concurrent checks on the ports of the feature control block
`timescale 1ns/1ps
`default_nettype none
`include "adc_feature_map.svh"
module adc_feature_ctrl_chk (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic control_pin_one,
  input wire logic control_pin_two,
  input wire logic control_pin_three,
  input wire adc_feature_pkg::sample_t raw_sample_a,
  input wire adc_feature_pkg::sample_t raw_sample_b,
  input wire adc_feature_pkg::sample_t first_channel_output_bus,
  input wire adc_feature_pkg::sample_t second_channel_output_bus,
  input wire logic noise_shaping_on_a,
  input wire logic noise_shaping_on_b,
  input wire adc_feature_pkg::filter_index_t active_filter_a,
  input wire adc_feature_pkg::bw_class_t active_class_a,
  input wire logic wide_rate_ref_a,
  input wire logic global_power_down,
  input wire logic standby_a,
  input wire logic mux_output
);
  import adc_feature_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ********
  // quiet span counter
  // ********
  // pin one high may mux channel A onto the second bus, so latency is judged only after 20 calm cycles
  logic [4:0] quiet;
  always_ff @(posedge sys_clk) begin
    if (srst || control_pin_one) begin
      quiet <= 5'h00;
    end else if (quiet != 5'h14) begin
      quiet <= quiet + 5'h01;
    end
  end
  // in mux mode the second bus must carry channel a every other cycle
  logic same_bus;
  assign same_bus = (second_channel_output_bus == first_channel_output_bus);
  // ********
  // checks
  // ********
  chk_reset_off: assert property (@(posedge sys_clk) disable iff (1'b0)
    $fell(srst) |-> !noise_shaping_on_a && !noise_shaping_on_b) else $error("shaping on after reset");
  chk_power_down: assert property (control_pin_one && !control_pin_two && !control_pin_three
    |=> global_power_down && !standby_a && !mux_output) else $error("power down decode wrong");
  chk_standby_a: assert property (control_pin_one && !control_pin_two && control_pin_three
    |=> standby_a && !global_power_down && !mux_output) else $error("standby decode wrong");
  chk_mux_code: assert property (control_pin_one && control_pin_two && control_pin_three
    |=> mux_output && !global_power_down && !standby_a) else $error("mux decode wrong");
  chk_reserved_code: assert property (control_pin_one && control_pin_two && !control_pin_three
    |=> !(global_power_down || standby_a || mux_output)) else $error("reserved code acted");
  chk_pin_one_low: assert property (!control_pin_one
    |=> !(global_power_down || standby_a || mux_output)) else $error("decode with pin one low");
  chk_filter_range: assert property (active_filter_a <= `FILTER_LAST) else $error("filter out of range");
  chk_wide_ref: assert property (wide_rate_ref_a == (active_filter_a >= `WIDE_CLASS_FIRST))
    else $error("rate reference wrong");
  chk_class_forty: assert property (active_filter_a >= 6'h1E && active_filter_a <= 6'h27
    |-> active_class_a == class_40) else $error("class wrong");
  chk_output_latency: assert property (quiet == 5'h14 |->
    first_channel_output_bus == $past(raw_sample_a, 16) && second_channel_output_bus == $past(raw_sample_b, 16))
    else $error("output latency wrong");
  chk_mux_interleave: assert property (mux_output && $past(mux_output) |-> same_bus || $past(same_bus))
    else $error("mux bus never shows channel a");
  cover property (noise_shaping_on_a && noise_shaping_on_b);
  cover property (mux_output);
  cover property (quiet == 5'h14 && wide_rate_ref_a);
endmodule
`default_nettype wire

//--- verification/host_pin_model.sv
// host side driver of the three control pins
`timescale 1ns/1ps
`default_nettype none
module host_pin_model (
  input wire logic sys_clk,
  input wire logic [2:0] pin_code,
  output logic control_pin_one,
  output logic control_pin_two,
  output logic control_pin_three
);
  // pins move just after an edge, as a registered host output would
  always @(posedge sys_clk) begin
    control_pin_one <= pin_code[2];
    control_pin_two <= pin_code[1];
    control_pin_three <= pin_code[0];
  end
endmodule
`default_nettype wire

//--- verification/adc_feature_ctrl_test.sv
// self-checking bench of the feature control block
`timescale 1ns/1ps
`default_nettype none
`include "adc_feature_map.svh"
module adc_feature_ctrl_test;
  import adc_feature_pkg::*;
  logic sys_clk, srst, reg_write, reg_read, control_pin_one, control_pin_two, control_pin_three;
  logic noise_shaping_on_a, noise_shaping_on_b, wide_rate_ref_a, wide_rate_ref_b;
  logic aux_features_on, global_power_down, standby_a, mux_output;
  logic [2:0] pin_code;
  reg_addr_t reg_addr;
  reg_data_t reg_wdata, reg_rdata;
  sample_t raw_sample_a, raw_sample_b, first_channel_output_bus, second_channel_output_bus;
  filter_index_t active_filter_a, active_filter_b;
  bw_class_t active_class_a, active_class_b;
  int failures, check_count;
  adc_feature_ctrl dut (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .control_pin_one, .control_pin_two, .control_pin_three, .raw_sample_a, .raw_sample_b,
    .first_channel_output_bus, .second_channel_output_bus, .noise_shaping_on_a, .noise_shaping_on_b,
    .active_filter_a, .active_filter_b, .active_class_a, .active_class_b, .wide_rate_ref_a,
    .wide_rate_ref_b, .aux_features_on, .global_power_down, .standby_a, .mux_output);
  host_pin_model host (.sys_clk, .pin_code, .control_pin_one, .control_pin_two, .control_pin_three);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    raw_sample_a <= raw_sample_a + 11'h001;
    raw_sample_b <= raw_sample_b + 11'h003;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask
  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input reg_addr_t a, input reg_data_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input reg_addr_t a, input reg_data_t exp, input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp, what);
  endtask
  task automatic pins(input logic [2:0] c);
    @(posedge sys_clk);
    pin_code <= c;
    settle();
  endtask
  // filter change always walks the whole sequence, mode bits cleared first
  task automatic cfg(input filter_index_t a, input filter_index_t b);
    wr(`ADDR_MODE, 32'h0);
    wr(`ADDR_FILTER_A, {26'h0, a});
    wr(`ADDR_FILTER_B, {26'h0, b});
    wr(`ADDR_MODE, 32'h2);
    settle();
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic test_reset;
    #1;
    chk({noise_shaping_on_b, noise_shaping_on_a}, 32'h0, "shaping after reset");
    rd(`ADDR_STATUS, 32'h0, "status after reset");
    rd(8'h14, 32'h0, "unmapped read");
    $display("test reset done");
  endtask
  task automatic test_pin_control;
    cfg(6'h05, 6'h1E);
    chk(active_filter_a, 32'h5, "filter a");
    chk(active_filter_b, 32'h1E, "filter b");
    chk({active_class_b, active_class_a}, {class_40, class_20}, "classes");
    chk({wide_rate_ref_b, wide_rate_ref_a}, 32'h2, "rate refs");
    chk(aux_features_on, 32'h0, "aux in shaping mode");
    for (int k = 0; k < 4; k++) begin
      pins({1'b0, k[1:0]});
      chk({noise_shaping_on_b, noise_shaping_on_a}, {k[0], k[1]}, "pin enables");
      rd(`ADDR_STATUS, {30'h0, k[0], k[1]}, "status pin enables");
    end
    $display("test pin control done");
  endtask
  task automatic test_pin_decodes;
    logic [2:0] code [4] = '{3'h4, 3'h5, 3'h6, 3'h7};
    logic [2:0] outs [4] = '{3'h1, 3'h2, 3'h0, 3'h4};
    int pos [4] = '{`ST_PDOWN_BIT, `ST_STBY_BIT, `ST_RSVD_BIT, `ST_MUX_BIT};
    for (int k = 0; k < 4; k++) begin
      pins(code[k]);
      chk({mux_output, standby_a, global_power_down}, outs[k], "pin decode");
      rd(`ADDR_STATUS, 32'h1 << pos[k], "status pin decode");
    end
    $display("test pin decodes done");
  endtask
  task automatic test_modes;
    pins(3'h3);
    wr(`ADDR_MODE, 32'h1);
    settle();
    chk({aux_features_on, noise_shaping_on_b, noise_shaping_on_a}, 32'h7, "mode 10");
    wr(`ADDR_MODE, 32'h3);
    settle();
    chk({aux_features_on, noise_shaping_on_b, noise_shaping_on_a}, 32'h7, "mode 11");
    wr(`ADDR_MODE, 32'h0);
    settle();
    chk({aux_features_on, noise_shaping_on_b, noise_shaping_on_a}, 32'h0, "mode 00");
    wr(`ADDR_MODE, 32'h2);
    settle();
    chk({aux_features_on, noise_shaping_on_b, noise_shaping_on_a}, 32'h3, "mode 01");
    $display("test modes done");
  endtask
  task automatic test_bypass;
    pins(3'h1);
    cfg(`FILTER_LAST, `FILTER_COUNT);
    chk(active_filter_a, `FILTER_LAST, "last filter");
    chk(active_class_a, class_60, "last class");
    chk(active_filter_b, 32'h1E, "index 55 refused");
    wr(`ADDR_CONTROL, 32'h3);
    settle();
    chk({noise_shaping_on_b, noise_shaping_on_a}, 32'h1, "register enable a");
    pins(3'h2);
    wr(`ADDR_CONTROL, 32'h5);
    settle();
    chk({noise_shaping_on_b, noise_shaping_on_a}, 32'h2, "register enable b");
    rd(`ADDR_STATUS, 32'h2, "status bypass");
    repeat (25) @(posedge sys_clk);
    $display("test bypass done");
  endtask
  task automatic test_second_reset;
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    settle();
    chk({noise_shaping_on_b, noise_shaping_on_a, active_filter_a}, 32'h0, "second reset");
    $display("test second reset done");
  endtask
  initial begin
    #50000;
    failures++;
    report_and_stop();
  end
  initial begin
    {srst, reg_write, reg_read, pin_code} = 6'h20;
    {reg_addr, reg_wdata, raw_sample_a, raw_sample_b} = '0;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    test_reset();
    test_pin_control();
    test_pin_decodes();
    test_modes();
    test_bypass();
    test_second_reset();
    report_and_stop();
  end
endmodule
bind adc_feature_ctrl adc_feature_ctrl_chk chk (.sys_clk, .srst, .control_pin_one, .control_pin_two,
  .control_pin_three, .raw_sample_a, .raw_sample_b, .first_channel_output_bus, .second_channel_output_bus,
  .noise_shaping_on_a, .noise_shaping_on_b, .active_filter_a, .active_class_a, .wide_rate_ref_a,
  .global_power_down, .standby_a, .mux_output);
`default_nettype wire
